// [verilog/hss_dev.sv]
// device end of the serial control port: shift logic, register bank,
// watchdog plausibility check and fail mode
// assumes: link pins come from another domain; diag words are static
//

`timescale 1ns/10ps

module hss_dev #(
  parameter int WD_CYC0 = hss_pkg::WD_CYC0,  // short timeout, cycles
  parameter int WD_CYC1 = hss_pkg::WD_CYC1   // long timeout, cycles
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  hss_link_if.dev                     link,
  input  wire logic [3:0]             direct_channel_inputs_in,
  input  wire logic [hss_pkg::NUM_DIAG*hss_pkg::WORD_W-1:0] diag_words_in,
  output logic [hss_pkg::NUM_SUB*hss_pkg::PAY_W-1:0] cfg_flat_out,
  output logic                        fail_mode_out,
  output logic                        wake_out,
  output logic                        frame_done_out
);
  import hss_pkg::*;

  // ----------------------------------------------------------------
  // synchronised pins and edges
  // ----------------------------------------------------------------
  logic [7:0]        pins_s;        // synchronised pin group
  logic              sclk_s;        // serial clock level
  logic              csn_s;         // chip select level
  logic              mosi_s;        // data input level
  logic              rpin_n_s;      // reset pin level
  logic [3:0]        dci_s;         // direct channel inputs
  logic              sclk_d_reg;    // previous clock level
  logic              csn_d_reg;     // previous select level
  logic              sclk_rise;     // rising serial clock
  logic              cs_fall;       // frame start
  logic              cs_rise;       // frame end
  logic              port_rst;      // port held in reset

  hss_sync #(.W(8)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       ({link.sclk, link.cs_n, link.mosi, link.reset_pin_n,
                  direct_channel_inputs_in}),
    .q_out      (pins_s)
  );

  assign {sclk_s, csn_s, mosi_s, rpin_n_s, dci_s} = pins_s;
  assign port_rst  = rst_in | ~rpin_n_s;
  assign sclk_rise = sclk_s & ~sclk_d_reg & ~csn_s;
  assign cs_fall   = ~csn_s & csn_d_reg;
  assign cs_rise   = csn_s & ~csn_d_reg;

  // edge history of clock and select
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sclk_d_reg <= 1'b0;
      csn_d_reg  <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
    end
  end

  // wake follows the reset pin or any direct input
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= rpin_n_s | (|dci_s);
    end
  end

  // ----------------------------------------------------------------
  // shift register and frame length
  // ----------------------------------------------------------------
  logic [PAY_W-1:0]  bank [NUM_SUB]; // stored payloads
  logic [WORD_W-1:0] shift_reg;     // in and out shift register
  logic              miso_reg;      // output bit
  logic [3:0]        bit_cnt_reg;   // bits modulo sixteen
  logic              clocked_reg;   // rising clock edge seen in frame
  logic [SOA_W-1:0]  out_sel;       // next response word
  logic              frame_ok;      // whole words received
  logic              frame_bad;     // length not a multiple of 16
  logic [3:0]        rx_addr;       // received address nibble
  logic              rx_wd;         // received watchdog bit
  logic [PAY_W-1:0]  rx_pay;        // received payload

  assign out_sel = bank[0][SOA_LSB +: SOA_W];

  // one register shifts both ways, so extra words pass straight on
  always_ff @(posedge sys_clk_in) begin
    if (port_rst) begin
      shift_reg   <= '0;
      miso_reg    <= 1'b0;
      bit_cnt_reg <= 4'h0;
      clocked_reg <= 1'b0;
    end else if (cs_fall) begin
      shift_reg   <= diag_words_in[out_sel*WORD_W +: WORD_W];
      bit_cnt_reg <= 4'h0;
      clocked_reg <= 1'b0;
    end else if (sclk_rise) begin
      miso_reg    <= shift_reg[WORD_W-1];
      shift_reg   <= {shift_reg[WORD_W-2:0], mosi_s};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      clocked_reg <= 1'b1;
    end
  end

  assign link.miso    = miso_reg;
  assign link.miso_oe = ~csn_s & rpin_n_s;

  assign frame_ok  = cs_rise & clocked_reg & (bit_cnt_reg == 4'h0);
  assign frame_bad = cs_rise & clocked_reg & (bit_cnt_reg != 4'h0);
  assign rx_addr   = shift_reg[ADDR_MSB:ADDR_LSB];
  assign rx_wd     = shift_reg[WD_BIT];
  assign rx_pay    = shift_reg[PAY_W-1:0];

  // ----------------------------------------------------------------
  // watchdog and fail mode
  // ----------------------------------------------------------------
  logic [31:0] wd_cnt_reg;          // cycles since last valid toggle
  logic [31:0] wd_limit;            // selected timeout
  logic        wd_expired;          // timeout reached
  logic        wd_last_reg;         // last accepted watchdog bit
  logic        armed_reg;           // recovery: zero frame seen
  logic        fail_reg;            // fail mode
  logic        fail_set;            // entering fail this cycle
  logic        wd_restart;          // restart the timeout
  logic        recover;             // leaving fail this cycle

  assign wd_limit   = bank[0][WATCHDOG_PERIOD_SELECT_BIT] ? WD_CYC1 : WD_CYC0;
  assign wd_expired = wd_cnt_reg >= wd_limit;
  assign fail_set   = ~fail_reg &
                      (wd_expired | frame_bad);
  assign recover    = fail_reg & frame_ok & rx_wd & armed_reg &
                      ~wd_expired;
  assign wd_restart = frame_ok & (fail_reg ? ~rx_wd : (rx_wd != wd_last_reg));

  // timeout counter, saturating once it has run out
  always_ff @(posedge sys_clk_in) begin
    if (port_rst | wd_restart) begin
      wd_cnt_reg <= 32'h0;
    end else if (!wd_expired) begin
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end
  end

  // fail mode entry, recovery sequence and watchdog history
  always_ff @(posedge sys_clk_in) begin
    if (port_rst) begin
      fail_reg    <= 1'b0;
      armed_reg   <= 1'b0;
      wd_last_reg <= 1'b0;
    end else if (fail_set) begin
      fail_reg    <= 1'b1;
      armed_reg   <= 1'b0;
    end else if (recover) begin
      fail_reg    <= 1'b0;
      armed_reg   <= 1'b0;
      wd_last_reg <= 1'b1;
    end else if (frame_ok) begin
      if (fail_reg) begin
        armed_reg <= ~rx_wd;
      end else begin
        wd_last_reg <= rx_wd;
      end
    end
  end

  assign fail_mode_out = fail_reg;

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] wr_idx;          // target entry
  logic             wr_en;           // accepted write

  assign wr_idx = sub_index(rx_addr, rx_pay[SUB_SEL_BIT]);
  assign wr_en  = frame_ok & ~fail_reg & ~fail_set &
                  (rx_addr != ADDR_FACTORY_TEST);

  // clear on reset, fail entry and recovery; masked write otherwise
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < NUM_SUB; i++) begin
      if (port_rst | fail_set | recover) begin
        bank[i] <= REG_RESET;
      end else if (wr_en && (wr_idx == IDX_W'(i))) begin
        bank[i] <= rx_pay & sub_mask(wr_idx);
      end
    end
  end

  // flatten the bank for the user side
  always_comb begin
    for (int i = 0; i < NUM_SUB; i++) begin
      cfg_flat_out[i*PAY_W +: PAY_W] = bank[i];
    end
  end

  // one pulse per frame of whole words, whether or not it is written
  always_ff @(posedge sys_clk_in) begin
    if (port_rst) begin
      frame_done_out <= 1'b0;
    end else begin
      frame_done_out <= frame_ok;
    end
  end
endmodule

// [verilog/hss_pkg.sv]
// shared constants, register map and helpers for the serial control port
// assumes: both ends and the bench import it; no other dependencies

package hss_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W      = 16;   // bits per frame word
  localparam int ADDR_MSB    = 15;   // top of address nibble
  localparam int ADDR_LSB    = 12;   // bottom of address nibble
  localparam int WD_BIT      = 11;   // watchdog toggle position
  localparam int SUB_SEL_BIT = 10;   // sub-register select position
  localparam int PAY_W       = 11;   // payload width below watchdog
  localparam int NUM_SUB     = 19;   // stored payload registers
  localparam int NUM_DIAG    = 16;   // selectable diagnostic words
  localparam int IDX_W       = 5;    // width of a bank index
  localparam int SOA_LSB     = 0;    // output word select field
  localparam int SOA_W       = 4;    // output word select width
  localparam int WATCHDOG_PERIOD_SELECT_BIT  = 10;   // watchdog period select
  localparam logic [PAY_W-1:0] REG_RESET = 11'h000;  // reset value

  // ----------------------------------------------------------------
  // device register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DEVICE_SETUP_ONE = 4'h0;
  localparam logic [3:0] ADDR_PROTECTION_SETUP = 4'h1;
  localparam logic [3:0] ADDR_CH1_DRIVE        = 4'h2;
  localparam logic [3:0] ADDR_CH6_DRIVE        = 4'h7;
  localparam logic [3:0] ADDR_OUTPUT_SWITCH    = 4'h8;
  localparam logic [3:0] ADDR_SHARED_PWM       = 4'h9;
  localparam logic [3:0] ADDR_OVERLOAD_PROFILE = 4'ha;
  localparam logic [3:0] ADDR_DIRECT_INPUT_EN  = 4'hb;
  localparam logic [3:0] ADDR_CLOCK_DIVIDER    = 4'hc;
  localparam logic [3:0] ADDR_OPEN_LOAD        = 4'hd;
  localparam logic [3:0] ADDR_DUTY_STEP        = 4'he;
  localparam logic [3:0] ADDR_FACTORY_TEST     = 4'hf;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ   = 25;     // sys_clk_in rate
  localparam int WD_TIME0_US   = 1000;   // short watchdog timeout
  localparam int WD_TIME1_US   = 4000;   // long watchdog timeout
  localparam int WD_CYC0       = WD_TIME0_US * SYS_CLK_MHZ;
  localparam int WD_CYC1       = WD_TIME1_US * SYS_CLK_MHZ;
  localparam int SCLK_HALF_CYC = 8;      // host clock half period

  // ----------------------------------------------------------------
  // host controller registers (apb byte offsets and fields)
  // ----------------------------------------------------------------
  localparam logic [11:0] HOST_CTRL_OFS = 12'h000;
  localparam logic [11:0] HOST_TX_OFS   = 12'h004;
  localparam logic [11:0] HOST_RX_OFS   = 12'h008;
  localparam logic [11:0] HOST_STAT_OFS = 12'h00c;
  localparam int CTRL_AUTO_WD_BIT = 0;   // insert watchdog bit
  localparam int CTRL_RST_REL_BIT = 1;   // drive reset pin high
  localparam int STAT_BUSY_BIT    = 0;   // frame in progress
  localparam int STAT_DONE_BIT    = 1;   // sticky frame finished
  localparam logic [1:0] CTRL_RESET = 2'h1;  // auto on, pin held low

  // map address and sub select bit onto a bank index
  function automatic logic [IDX_W-1:0] sub_index(input logic [3:0] a,
                                                 input logic sel);
    logic [IDX_W-1:0] s;
    s = {4'h0, sel};
    case (a)
      ADDR_SHARED_PWM:       sub_index = 5'h09 + s;
      ADDR_OVERLOAD_PROFILE: sub_index = 5'h0b + s;
      ADDR_DIRECT_INPUT_EN:  sub_index = 5'h0d;
      ADDR_CLOCK_DIVIDER:    sub_index = 5'h0e + s;
      ADDR_OPEN_LOAD:        sub_index = 5'h10 + s;
      ADDR_DUTY_STEP:        sub_index = 5'h12;
      default:               sub_index = {1'b0, a};
    endcase
  endfunction

  // bits of each bank entry that carry meaning; the rest store zero
  function automatic logic [PAY_W-1:0] sub_mask(input logic [IDX_W-1:0] i);
    case (i)
      5'h09:   sub_mask = 11'h03f;  // shared pwm enables
      5'h0a:   sub_mask = 11'h0ff;  // shared pwm duty
      5'h0b:   sub_mask = 11'h3ff;
      5'h0c:   sub_mask = 11'h3ff;
      5'h0d:   sub_mask = 11'h0ff;  // direct input enable
      5'h0e:   sub_mask = 11'h3ff;
      5'h0f:   sub_mask = 11'h003;  // divider high bits
      5'h10:   sub_mask = 11'h3ff;
      5'h11:   sub_mask = 11'h03f;  // led open load, reserved cut
      default: sub_mask = 11'h7ff;
    endcase
  endfunction

endpackage

// [verilog/hss_link_if.sv]
// serial link between the controller and the switch device
// assumes: bench resolves the data-out wire from miso_oe

`timescale 1ns/10ps

interface hss_link_if;
  logic sclk;         // serial clock, made by host
  logic cs_n;         // chip_select_n, active low frame
  logic mosi;         // host to device data
  logic miso;         // device to host data
  logic miso_oe;      // device drives miso while high
  logic reset_pin_n;  // reset_pin_n, active low

  modport dev  (input sclk, cs_n, mosi, reset_pin_n,
                output miso, miso_oe);
  modport host (output sclk, cs_n, mosi, reset_pin_n,
                input miso);
endinterface

// [verilog/hss_sync.sv]
// two flip-flop synchroniser for a group of independent levels
// assumes: each bit is a slow level or clock seen by sys_clk_in

`timescale 1ns/10ps

module hss_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;  // first stage, read only by second

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// [verilog/hss_host.sv]
// controller end: apb slave registers drive one serial frame at a time
// assumes: apb runs on sys_clk_in; device sits on the link interface

`timescale 1ns/10ps

module hss_host #(
  parameter int HALF_CYC = hss_pkg::SCLK_HALF_CYC  // sclk half period
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  hss_link_if.host         link
);
  import hss_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_LEAD  = 3'b001,
    HS_HIGH  = 3'b011,
    HS_LOW   = 3'b010,
    HS_TRAIL = 3'b110,
    HS_GAP   = 3'b111
  } hss_state_e;

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  hss_state_e        state_reg;     // frame sequencer
  logic [1:0]        ctrl_reg;      // auto watchdog, reset release
  logic [WORD_W-1:0] rx_reg;        // last received word
  logic              done_reg;      // sticky frame finished
  logic              wd_reg;        // last watchdog bit sent
  logic              wr_acc;        // write access phase
  logic              mapped;        // address decodes
  logic              start;         // tx write while idle
  logic              frame_end;     // sequencer returns idle
  logic              busy;          // frame in progress

  assign busy        = (state_reg != HS_IDLE);
  assign mapped      = (paddr_in == HOST_CTRL_OFS) |
                       (paddr_in == HOST_TX_OFS) |
                       (paddr_in == HOST_RX_OFS) | (paddr_in == HOST_STAT_OFS);
  assign wr_acc      = psel_in & penable_in & pwrite_in & mapped;
  assign start       = wr_acc & (paddr_in == HOST_TX_OFS) & ~busy;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;

  // read mux, zero on unmapped addresses
  always_comb begin
    case (paddr_in)
      HOST_CTRL_OFS: prdata_out = {30'h0, ctrl_reg};
      HOST_RX_OFS:   prdata_out = {16'h0, rx_reg};
      HOST_STAT_OFS: prdata_out = {30'h0, done_reg, busy};
      default:       prdata_out = 32'h0;
    endcase
  end

  // control register; a write also restarts the watchdog pattern
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_acc && paddr_in == HOST_CTRL_OFS) begin
      ctrl_reg <= pwdata_in[1:0];
    end
  end

  // sticky done: a finishing frame beats a clear in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      done_reg <= 1'b0;
    end else if (frame_end) begin
      done_reg <= 1'b1;
    end else if (wr_acc && paddr_in == HOST_STAT_OFS &&
                 pwdata_in[STAT_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // watchdog bit history; ctrl write sets it so zero goes next
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wd_reg <= 1'b0;
    end else if (wr_acc && paddr_in == HOST_CTRL_OFS) begin
      wd_reg <= 1'b1;
    end else if (start && ctrl_reg[CTRL_AUTO_WD_BIT]) begin
      wd_reg <= ~wd_reg;
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  logic [7:0]        tmr_reg;       // half period timer
  logic [3:0]        bits_reg;      // bits remaining minus one
  logic [WORD_W-1:0] tx_reg;        // outgoing shift register
  logic              miso_s;        // synchronised data in
  logic              tick;          // half period elapsed

  hss_sync #(.W(1)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (link.miso),
    .q_out      (miso_s)
  );

  assign tick      = (tmr_reg == 8'(HALF_CYC - 1));
  assign frame_end = (state_reg == HS_GAP) & tick;
  assign link.reset_pin_n = ctrl_reg[CTRL_RST_REL_BIT];
  assign link.mosi = tx_reg[WORD_W-1];

  // half period timer restarts on every phase change
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || state_reg == HS_IDLE || tick) begin
      tmr_reg <= 8'h0;
    end else begin
      tmr_reg <= tmr_reg + 8'h1;
    end
  end

  // clock phases: device samples on rising, host on falling
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= HS_IDLE;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      tx_reg    <= '0;
      rx_reg    <= '0;
      bits_reg  <= 4'h0;
    end else begin
      case (state_reg)
        HS_IDLE: begin
          if (start) begin
            tx_reg    <= ctrl_reg[CTRL_AUTO_WD_BIT] ?
                         {pwdata_in[15:12], ~wd_reg, pwdata_in[10:0]} :
                         pwdata_in[15:0];
            link.cs_n <= 1'b0;
            bits_reg  <= 4'hf;
            state_reg <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (tick) begin
            link.sclk <= 1'b1;
            state_reg <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tick) begin
            link.sclk <= 1'b0;
            rx_reg    <= {rx_reg[WORD_W-2:0], miso_s};
            tx_reg    <= {tx_reg[WORD_W-2:0], 1'b0};
            state_reg <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick) begin
            if (bits_reg == 4'h0) begin
              state_reg <= HS_TRAIL;
            end else begin
              bits_reg  <= bits_reg - 4'h1;
              link.sclk <= 1'b1;
              state_reg <= HS_HIGH;
            end
          end
        end
        HS_TRAIL: begin
          if (tick) begin
            link.cs_n <= 1'b1;
            state_reg <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (tick) begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end
endmodule

// [tb/hss_assertions.sv]
// concurrent checks on the link joining host and device
// assumes: instantiated beside the link interface, one clock domain
`timescale 1ns/10ps
module hss_assertions (
  input wire logic sys_clk_in,     // bench clock
  input wire logic rst_in,         // bench reset, active high
  input wire logic sclk_in,        // link serial clock
  input wire logic cs_n_in,        // link select, active low
  input wire logic mosi_in,        // host to device data
  input wire logic miso_in,        // device to host data
  input wire logic miso_oe_in,     // device drives miso while high
  input wire logic reset_pin_n_in  // link reset pin, active low
);
  logic [4:0] bits_reg;  // rising serial clocks in the current frame
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // count serial clock rises, restarted at each select fall
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || $fell(cs_n_in)) begin
      bits_reg <= 5'h00;
    end else if ($rose(sclk_in)) begin
      bits_reg <= bits_reg + 5'h01;
    end
  end
  // select held low with the port awake, past the pin synchronisers
  sequence s_frame4;
    (!cs_n_in && reset_pin_n_in)[*4];
  endsequence
  // serial clock stays low through the lead-in half period
  sequence s_lead8;
    (!sclk_in)[*8];
  endsequence
  a_oe_idle: assert property (cs_n_in[*4] |-> !miso_oe_in)
    else $error("miso driven while select high");
  a_oe_frame: assert property (s_frame4 |-> miso_oe_in)
    else $error("miso not driven inside frame");
  a_oe_pin_low: assert property (
      (!reset_pin_n_in)[*4] |-> !miso_oe_in)
    else $error("miso driven while reset pin low");
  a_clk_idle: assert property (cs_n_in |-> !sclk_in)
    else $error("serial clock high outside frame");
  a_lead_gap: assert property ($fell(cs_n_in) |-> s_lead8)
    else $error("serial clock too soon after select fall");
  a_mosi_hold: assert property (
      $rose(sclk_in) |=> $stable(mosi_in)[*7])
    else $error("mosi moved while clock high");
  a_miso_settle: assert property (
      $rose(sclk_in) |-> ##6 $stable(miso_in)[*2])
    else $error("miso not settled before falling edge");
  a_word_count: assert property (
      $rose(cs_n_in) |-> bits_reg == 5'h10)
    else $error("frame not sixteen bits");
  a_host_reset: assert property (disable iff (1'b0)
      rst_in |=> cs_n_in && !sclk_in && !reset_pin_n_in)
    else $error("host link pins wrong in reset");
endmodule

// [tb/tb_hss.sv]
// bench: apb stimulus into the host, device on the far side of the link
// assumes: host and device joined by one link interface
`timescale 1ns/10ps
module tb_hss;
  import hss_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e, rdy, err, fl, wk;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic [3:0] din = 0, k;
  logic [255:0] dg;  // diagnostic words offered by the device
  logic [208:0] cfg;
  logic [10:0] ex [19];  // expected bank contents
  int fails = 0, total_checks = 0;
  int nf = 0, nd = 0;  // frames sent, commit pulses seen
  logic fd;            // device commit pulse
  hss_link_if link ();
  always #20 clk = ~clk;
  hss_host #(.HALF_CYC(8)) u_hss_host (.sys_clk_in(clk), .rst_in(rst),
    .paddr_in(pa), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .link(link));
  hss_dev #(.WD_CYC0(2000), .WD_CYC1(4000)) u_hss_dev (.sys_clk_in(clk),
    .rst_in(rst), .link(link), .direct_channel_inputs_in(din),
    .diag_words_in(dg), .cfg_flat_out(cfg), .fail_mode_out(fl),
    .wake_out(wk), .frame_done_out(fd));
  hss_assertions u_hss_assertions (.sys_clk_in(clk), .rst_in(rst),
    .sclk_in(link.sclk), .cs_n_in(link.cs_n), .mosi_in(link.mosi),
    .miso_in(link.miso), .miso_oe_in(link.miso_oe),
    .reset_pin_n_in(link.reset_pin_n));
  // count whole-word commit pulses from the device
  always @(posedge clk) begin
    if (fd === 1'b1) nd <= nd + 1;
  end
  // one apb transfer; read data and error land in r and e
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    r = prd;
    e = err;
    {psel, pen} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // send one word, wait for done, clear it, fetch the reply
  task automatic frm(input logic [15:0] w);
    nf++;
    apb(1'b1, HOST_TX_OFS, {16'h0000, w});
    do begin
      apb(1'b0, HOST_STAT_OFS, 32'h0);
    end while (r[STAT_DONE_BIT] !== 1'b1);
    apb(1'b1, HOST_STAT_OFS, 32'h2);
    repeat (4) @(posedge clk);
    apb(1'b0, HOST_RX_OFS, 32'h0);
  endtask
  task automatic bank();
    for (int i = 0; i < 19; i++) begin
      chk("bank", 32'(cfg[i*11+:11]), 32'(ex[i]));
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    end_sim();
  end
  initial begin
    logic [10:0] p;
    logic [3:0] a;
    r = $urandom(19558);
    for (int i = 0; i < 8; i++) dg[i*32+:32] = $urandom();
    foreach (ex[i]) ex[i] = 11'h000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    din <= 4'h5;
    repeat (6) @(posedge clk);
    chk("wake_in", 32'(wk), 32'h1);
    din <= 4'h0;
    repeat (6) @(posedge clk);
    chk("wake_off", 32'(wk), 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'(e), 32'h1);
    apb(1'b1, HOST_CTRL_OFS, 32'h3);
    repeat (8) @(posedge clk);
    chk("wake_pin", 32'(wk), 32'h1);
    bank();
    k = 4'($urandom());
    frm({12'h000, k});
    ex[0] = {7'h00, k};
    for (int i = 0; i < 8; i++) begin
      a = 4'($urandom_range(1, 8));
      p = 11'($urandom());
      frm({a, 1'b0, p});
      ex[a] = p;
      chk("rx", r, 32'(dg[k*16+:16]));
    end
    chk("no_fail", 32'(fl), 32'h0);
    p = 11'($urandom()) | 11'h400;
    frm({4'h9, 1'b0, p});
    ex[10] = p & 11'h0ff;
    frm(16'hffff);
    bank();
    repeat (2100) @(posedge clk);
    chk("fail_wd", 32'(fl), 32'h1);
    foreach (ex[i]) ex[i] = 11'h000;
    frm({4'h2, 12'h155});
    bank();
    apb(1'b1, HOST_CTRL_OFS, 32'h3);
    frm(16'h0000);
    frm(16'h0000);
    chk("recover", 32'(fl), 32'h0);
    chk("frames", 32'(nd), 32'(nf));
    end_sim();
  end
endmodule
